// >>> hw/mss_map.vh
`ifndef MSS_MAP_VH
`define MSS_MAP_VH
// Register byte addresses (Avalon word aligned)
`define ADDR_STAT_A 6'h00
`define ADDR_STAT_B 6'h04
`define ADDR_OPERAND 6'h08
`define ADDR_CTRL 6'h0c
`define ADDR_MCAND 6'h10
`define ADDR_PROD 6'h14
`define ADDR_PSHIFT 6'h18
`define ADDR_ACC 6'h1c
`define ADDR_ACC_IN 6'h20
`define ADDR_ISHIFT 6'h24
`define ADDR_OSHIFT 6'h28
`define ADDR_WBUS 6'h2c
`define ADDR_TEST 6'h30
// Status A fields
`define SA_SAT_BIT 11
`define SA_OVF_BIT 12
// Status B fields
`define SB_PM_LO 0
`define SB_XF_BIT 4
`define SB_SX_BIT 10
`define SB_TC_BIT 11
// Reset values
`define STAT_A_RST 16'h0000
`define STAT_B_RST 16'h0000
// Product shift modes
`define PM_NONE 2'h0
`define PM_L1 2'h1
`define PM_L4 2'h2
`define PM_R6 2'h3
// Control register command bits
`define CTL_MUL_BIT 0
`define CTL_SIGNED_BIT 1
`define CTL_ADD_BIT 2
`define CTL_SUB_BIT 3
`define CTL_LOAD_BIT 4
`define CTL_DYN_BIT 5
`define CTL_ADDP_BIT 6
`define CTL_BIT_TEST_DYNAMIC_BIT 7
`define CTL_HIGH_BIT 8
// Saturation values
`define ACC_MAX 32'h7fffffff
`define ACC_MIN 32'h80000000
`endif

// >>> hw/mult_shift_sat.v
// Function
// - Signed or unsigned 16x16 to 32-bit multiply
// - Product register holds until next multiply
// - Product shifter: none, left1, left4, right6
// - Status B bits 1:0 select product shift
// - Operand register feeds multiply, shifts, bit tests
// - Output shifter left 0-7, high/low half out
// - Input shifter places data left 0-16
// - Status B bit 10 enables sign extension
// - Status A bit 12 flags accumulator overflow
// - Status A bit 11 enables saturation
// - Saturate to most positive or negative
// - Status B bit 11 holds test result
// - Status B bit 4 drives external flag pin
// - Both status registers readable and writable
// - Sign extension copies value's top bit
// - Zero fill for unused bit positions
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.vh"
module mult_shift_sat (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Avalon-MM slave
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // External flag pin
  output reg external_flag_pin
);

  reg [15:0] stat_a_ff;
  reg [15:0] stat_b_ff;
  reg [15:0] multiply_operand_holding_ff;
  reg [15:0] mcand_ff;
  reg [31:0] product_holding_register_ff;
  reg [31:0] acc_ff;
  reg [15:0] acc_in_ff;
  reg [4:0] ishift_ff;
  reg [2:0] oshift_ff;
  reg [15:0] wbus_ff;
  reg ack_ff;
  reg [31:0] nxt_acc;
  reg nxt_ovf;

  // Byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge16[7:0] = be[0] ? wd[7:0] : old[7:0];
      merge16[15:8] = be[1] ? wd[15:8] : old[15:8];
    end
  endfunction

  // Left shift of a 16-bit value into 32 bits with optional sign fill
  function [31:0] place;
    input [15:0] val;
    input [4:0] sh;
    input sx;
    reg [31:0] ext;
    begin
      ext = sx ? {{16{val[15]}}, val} : {16'h0000, val};
      place = ext << sh;
    end
  endfunction

  // Add with overflow detect and saturation
  function [32:0] sat_add;
    input [31:0] a;
    input [31:0] b;
    input sat_en;
    reg [31:0] s;
    reg ov;
    begin
      s = a + b;
      ov = (a[31] == b[31]) && (s[31] != a[31]);
      if (ov && sat_en) begin
        s = a[31] ? `ACC_MIN : `ACC_MAX;
      end
      sat_add = {ov, s};
    end
  endfunction

  // Sign-aware 16x16 multiply
  wire sgn_mul = writedata[`CTL_SIGNED_BIT];
  wire [31:0] prod_s = $signed(multiply_operand_holding_ff) * $signed(mcand_ff);
  wire [31:0] prod_u = multiply_operand_holding_ff * mcand_ff;
  wire [31:0] prod_new = sgn_mul ? prod_s : prod_u;

  // Product shifter
  reg [31:0] pshift;
  always @* begin
    case (stat_b_ff[`SB_PM_LO+1:`SB_PM_LO])
      `PM_NONE: pshift = product_holding_register_ff;
      `PM_L1: pshift = product_holding_register_ff << 1;
      `PM_L4: pshift = product_holding_register_ff << 4;
      `PM_R6: pshift = {{6{product_holding_register_ff[31]}},
                        product_holding_register_ff[31:6]};
      default: pshift = product_holding_register_ff;
    endcase
  end

  // Output shifter
  wire [31:0] oshifted = acc_ff << oshift_ff;

  // Input shifter, static or dynamic count
  wire sx = stat_b_ff[`SB_SX_BIT];
  wire [4:0] dyn_cnt = {1'b0, multiply_operand_holding_ff[3:0]};
  wire [4:0] cnt = writedata[`CTL_DYN_BIT] ? dyn_cnt : ishift_ff;
  wire [31:0] in_val = place(acc_in_ff, cnt, sx);

  wire wr_ctl = write && !waitrequest && (address == `ADDR_CTRL);

  // Accumulator command evaluation
  reg [32:0] r;
  always @* begin
    nxt_acc = acc_ff;
    nxt_ovf = 1'b0;
    r = 33'h0;
    if (wr_ctl) begin
      if (writedata[`CTL_LOAD_BIT]) begin
        nxt_acc = in_val;
      end else if (writedata[`CTL_ADD_BIT]) begin
        r = sat_add(acc_ff, in_val, stat_a_ff[`SA_SAT_BIT]);
        nxt_acc = r[31:0];
        nxt_ovf = r[32];
      end else if (writedata[`CTL_SUB_BIT]) begin
        r = sat_add(acc_ff, ~in_val + 32'h1, stat_a_ff[`SA_SAT_BIT]);
        nxt_acc = r[31:0];
        nxt_ovf = r[32] || (in_val == `ACC_MIN && !acc_ff[31]);
        // Negating the most negative value wraps; saturate that case too
        if (in_val == `ACC_MIN && !acc_ff[31] && stat_a_ff[`SA_SAT_BIT]) begin
          nxt_acc = `ACC_MAX;
        end
      end else if (writedata[`CTL_ADDP_BIT]) begin
        r = sat_add(acc_ff, pshift, stat_a_ff[`SA_SAT_BIT]);
        nxt_acc = r[31:0];
        nxt_ovf = r[32];
      end
    end
  end

  // Bit test at dynamic position
  wire bit_hit = acc_in_ff[4'hf - multiply_operand_holding_ff[3:0]];

  // Register file and datapath state
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_a_ff <= `STAT_A_RST;
      stat_b_ff <= `STAT_B_RST;
      multiply_operand_holding_ff <= 16'h0000;
      mcand_ff <= 16'h0000;
      product_holding_register_ff <= 32'h00000000;
      acc_ff <= 32'h00000000;
      acc_in_ff <= 16'h0000;
      ishift_ff <= 5'h00;
      oshift_ff <= 3'h0;
      wbus_ff <= 16'h0000;
    end else begin
      acc_ff <= nxt_acc;
      // Write bus captured only on a command write
      if (wr_ctl) begin
        wbus_ff <= writedata[`CTL_HIGH_BIT] ? oshifted[31:16] : oshifted[15:0];
      end
      if (write && !waitrequest) begin
        case (address)
          `ADDR_STAT_A: stat_a_ff <= merge16(stat_a_ff, writedata, byteenable);
          `ADDR_STAT_B: stat_b_ff <= merge16(stat_b_ff, writedata, byteenable);
          `ADDR_OPERAND: multiply_operand_holding_ff <= merge16(multiply_operand_holding_ff,
                                                               writedata, byteenable);
          `ADDR_MCAND: mcand_ff <= merge16(mcand_ff, writedata, byteenable);
          `ADDR_ACC: acc_ff <= writedata;
          `ADDR_ACC_IN: acc_in_ff <= merge16(acc_in_ff, writedata, byteenable);
          `ADDR_ISHIFT: ishift_ff <= (writedata[4:0] > 5'h10) ? 5'h10 : writedata[4:0];
          `ADDR_OSHIFT: oshift_ff <= writedata[2:0];
          default: ;
        endcase
      end
      if (wr_ctl && writedata[`CTL_MUL_BIT]) begin
        product_holding_register_ff <= prod_new;
      end
      if (wr_ctl && writedata[`CTL_BIT_TEST_DYNAMIC_BIT]) begin
        stat_b_ff[`SB_TC_BIT] <= bit_hit;
      end
      // Overflow sticky; set wins over software clear
      if (nxt_ovf) begin
        stat_a_ff[`SA_OVF_BIT] <= 1'b1;
      end
    end
  end

  // Avalon handshake: one wait cycle, then ack
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      external_flag_pin <= 1'b0;
    end else begin
      external_flag_pin <= stat_b_ff[`SB_XF_BIT];
      ack_ff <= (read || write) && waitrequest && !ack_ff;
      waitrequest <= !((read || write) && waitrequest && !ack_ff);
      if (read && waitrequest && !ack_ff) begin
        case (address)
          `ADDR_STAT_A: readdata <= {16'h0000, stat_a_ff};
          `ADDR_STAT_B: readdata <= {16'h0000, stat_b_ff};
          `ADDR_OPERAND: readdata <= {16'h0000, multiply_operand_holding_ff};
          `ADDR_MCAND: readdata <= {16'h0000, mcand_ff};
          `ADDR_PROD: readdata <= product_holding_register_ff;
          `ADDR_PSHIFT: readdata <= pshift;
          `ADDR_ACC: readdata <= acc_ff;
          `ADDR_ACC_IN: readdata <= {16'h0000, acc_in_ff};
          `ADDR_ISHIFT: readdata <= {27'h0, ishift_ff};
          `ADDR_OSHIFT: readdata <= {29'h0, oshift_ff};
          `ADDR_WBUS: readdata <= {16'h0000, wbus_ff};
          `ADDR_TEST: readdata <= {31'h0, stat_b_ff[`SB_TC_BIT]};
          default: readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // mult_shift_sat
`default_nettype wire

// >>> verif/mss_host.sv
`timescale 1ns/1ps
`default_nettype none
module mss_host (
  // Clock
  input wire clk,
  // Avalon-MM master
  output logic [5:0] address = 6'h00,
  output logic read = 1'b0,
  output logic write = 1'b0,
  output logic [31:0] writedata = 32'h0,
  output logic [3:0] byteenable = 4'hf,
  input wire [31:0] readdata,
  input wire waitrequest
);
  // Write held until accepted, data scrambled after
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    @(posedge clk);
    while (waitrequest) @(posedge clk);
    write <= 1'b0;
    writedata <= ~d;
    @(posedge clk);
  endtask
  // Read held until answered
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    address <= a;
    read <= 1'b1;
    @(posedge clk);
    while (waitrequest) @(posedge clk);
    d = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask
endmodule // mss_host
`default_nettype wire

// >>> verif/mult_shift_sat_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mult_shift_sat_chk (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register bus
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Flag pin
  input wire external_flag_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Bus answers and read-only views
  AST_WAIT_ANS: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered");
  AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  AST_WAIT_IDLE: assert property (!(read || write) |=> waitrequest)
    else $error("answer without request");
  AST_FLAG_WR: assert property (write && !waitrequest && address == 6'h04 && byteenable[0]
    |=> ##1 external_flag_pin == $past(writedata[4], 2))
    else $error("flag pin not following write");
  AST_FLAG_RD: assert property (read && !waitrequest && address == 6'h04
    |-> readdata[4] == external_flag_pin)
    else $error("flag bit differs from pin");
  AST_STAT_W16: assert property (read && !waitrequest && address <= 6'h04
    |-> readdata[31:16] == 16'h0000)
    else $error("status wider than 16 bits");
  AST_UNMAPPED: assert property (read && !waitrequest && address > 6'h30
    |-> readdata == 32'h00000000)
    else $error("unmapped read not zero");
  AST_OSH_RANGE: assert property (read && !waitrequest && address == 6'h28
    |-> readdata[31:3] == 29'h0)
    else $error("output shift above 7");
  AST_ISH_RANGE: assert property (read && !waitrequest && address == 6'h24
    |-> readdata <= 32'h00000010)
    else $error("input shift above 16");
  AST_RD_HOLD: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data changed without read");
  // Main scenarios
  cover property (write && !waitrequest && address == 6'h0c);
  cover property (read && !waitrequest && address == 6'h14);
  cover property (read && !waitrequest && address == 6'h3c);
endmodule // mult_shift_sat_chk
bind mult_shift_sat mult_shift_sat_chk u_chk (.clk(clk), .rstn(rstn), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .external_flag_pin(external_flag_pin));
`default_nettype wire

// >>> verif/tb_mult_shift_sat.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mult_shift_sat;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire [5:0] address;
  wire read;
  wire write;
  wire [31:0] writedata;
  wire [3:0] byteenable;
  wire [31:0] readdata;
  wire waitrequest;
  wire external_flag_pin;
  int errors = 0;
  int tests_run = 0;
  // Clock
  always #5 clk = ~clk;
  mult_shift_sat u_dut (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .external_flag_pin(external_flag_pin));
  mss_host h (.clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    h.rd(a, d);
    ck(d, e);
  endtask
  task report_and_stop;
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task t_status;
    rc(6'h00, 32'h0);
    h.wr(6'h04, 32'h413);
    rc(6'h04, 32'h413);
    h.wr(6'h04, 32'h10);
    repeat (2) @(posedge clk);
    ck({31'h0, external_flag_pin}, 32'h1);
    h.wr(6'h04, 32'h0);
    repeat (2) @(posedge clk);
    ck({31'h0, external_flag_pin}, 32'h0);
    rc(6'h3c, 32'h0);
  endtask
  task t_mul;
    h.wr(6'h08, 32'hffff);
    h.wr(6'h10, 32'h2);
    h.wr(6'h0c, 32'h1);
    rc(6'h14, 32'h1fffe);
    h.wr(6'h0c, 32'h3);
    rc(6'h14, 32'hfffffffe);
    h.wr(6'h08, 32'h1234);
    rc(6'h14, 32'hfffffffe);
  endtask
  task t_pshift;
    logic [31:0] p;
    h.wr(6'h08, 32'h8000);
    h.wr(6'h10, 32'h3);
    h.wr(6'h0c, 32'h3);
    p = 32'hfffe8000;
    for (int m = 0; m < 4; m++) begin
      h.wr(6'h04, 32'(m));
      rc(6'h18, m == 0 ? p : m == 1 ? p << 1 : m == 2 ? p << 4 : 32'($signed(p) >>> 6));
    end
  endtask
  task t_shifters;
    h.wr(6'h24, 32'd20);
    rc(6'h24, 32'd16);
    h.wr(6'h20, 32'h8001);
    h.wr(6'h24, 32'd4);
    h.wr(6'h04, 32'h0);
    h.wr(6'h0c, 32'h10);
    rc(6'h1c, 32'h00080010);
    h.wr(6'h04, 32'h400);
    h.wr(6'h0c, 32'h10);
    rc(6'h1c, 32'hfff80010);
    h.wr(6'h04, 32'h0);
    h.wr(6'h1c, 32'h12345678);
    h.wr(6'h28, 32'd4);
    rc(6'h28, 32'd4);
    h.wr(6'h0c, 32'h0);
    rc(6'h2c, 32'h6780);
    h.wr(6'h0c, 32'h100);
    rc(6'h2c, 32'h2345);
  endtask
  task t_sat;
    h.wr(6'h20, 32'h1);
    h.wr(6'h24, 32'h0);
    h.wr(6'h1c, 32'h7fffffff);
    h.wr(6'h0c, 32'h4);
    rc(6'h1c, 32'h80000000);
    rc(6'h00, 32'h1000);
    h.wr(6'h00, 32'h800);
    h.wr(6'h1c, 32'h7fffffff);
    h.wr(6'h0c, 32'h4);
    rc(6'h1c, 32'h7fffffff);
    h.wr(6'h1c, 32'h80000000);
    h.wr(6'h0c, 32'h8);
    rc(6'h1c, 32'h80000000);
    rc(6'h00, 32'h1800);
    h.wr(6'h00, 32'h0);
    rc(6'h00, 32'h0);
  endtask
  task t_dyn;
    h.wr(6'h08, 32'h4);
    h.wr(6'h20, 32'h0801);
    h.wr(6'h24, 32'h0);
    h.wr(6'h0c, 32'h30);
    rc(6'h1c, 32'h00008010);
    h.wr(6'h0c, 32'h80);
    rc(6'h30, 32'h1);
    rc(6'h04, 32'h800);
    h.wr(6'h08, 32'h3);
    h.wr(6'h0c, 32'h80);
    rc(6'h30, 32'h0);
    h.wr(6'h10, 32'h5);
    h.wr(6'h0c, 32'h1);
    h.wr(6'h04, 32'h2);
    h.wr(6'h0c, 32'h40);
    rc(6'h1c, 32'h00008100);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_status();
    t_mul();
    t_pshift();
    t_shifters();
    t_sat();
    t_dyn();
    report_and_stop();
  end
  // Watchdog
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule // tb_mult_shift_sat
`default_nettype wire
